// [tmc_regs.vh]
// Purpose: register offsets, field positions, reset values for the timer mode control block
// Assumes: word-addressed plain register port, 32-bit data
// Notes: offsets of the status/clear/enable registers are local choices
`ifndef TMC_REGS_VH
`define TMC_REGS_VH
`define TMC_ADDR_W 4
`define TMC_OFS_MODE 4'h0
`define TMC_OFS_PRSC 4'h1
`define TMC_OFS_CNT1 4'h2
`define TMC_OFS_CNT2 4'h3
`define TMC_OFS_CRA 4'h4
`define TMC_OFS_CRB 4'h5
`define TMC_OFS_PEND 4'h6
`define TMC_OFS_IRQ_STAT 4'h7
`define TMC_OFS_IRQ_CLR 4'h8
`define TMC_OFS_IRQ_EN 4'h9
`define TMC_B_MODE_LO 0
`define TMC_B_MODE_HI 1
`define TMC_B_AEDG 2
`define TMC_B_BEDG 3
`define TMC_B_AEN 4
`define TMC_B_BEN 5
`define TMC_B_AOUT 6
`define TMC_B_EN 7
`define TMC_B_PTEN 8
`define TMC_MODE_W 9
`define TMC_MODE_RST 9'h000
`define TMC_MD_PWM 2'h0
`define TMC_MD_CAPT2 2'h1
`define TMC_MD_DUAL 2'h2
`define TMC_MD_SINGLE 2'h3
`define TMC_PRESET_VAL 16'hFFFF
`define TMC_IRQ_W 3
`define TMC_EV_PRESET 0
`define TMC_EV_BEDGE 1
`define TMC_EV_TICK 2
`endif

// [tmc_timer_mode_control.v]
// Purpose: mode control, pin configuration and prescaler of a multifunction timer
// Assumes: one 10 MHz clock, pins synchronised here, register port with read data one cycle later
// Notes: counters here are minimal holders so presets and write blocking are observable
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "tmc_regs.vh"
module tmc_timer_mode_control #(
  parameter CNT_W = 16,
  parameter PRSC_W = 8
) (
  // clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // register port
  input wire [`TMC_ADDR_W-1:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  // timer pins
  input wire pin_a_i,
  output reg pin_a_o,
  output reg pin_a_oe_n_o,
  input wire pin_b_i,
  // status towards the rest of the timer
  output reg timer_tick_o,
  output reg pulse_train_active_o,
  output reg [1:0] mode_o,
  output reg irq_o
);

  reg [`TMC_MODE_W-1:0] mode_ctrl;
  reg [PRSC_W-1:0] clock_prescaler_value;
  reg [PRSC_W-1:0] prsc_cnt;
  reg [CNT_W-1:0] counter_one;
  reg [CNT_W-1:0] counter_two;
  reg [CNT_W-1:0] capture_reload_a;
  reg [CNT_W-1:0] capture_reload_b;
  reg [3:0] interrupt_pending_bits;
  reg [`TMC_IRQ_W-1:0] irq_stat;
  reg [`TMC_IRQ_W-1:0] irq_en;
  reg pin_a_s1, pin_a_s2, pin_a_s3;
  reg pin_b_s1, pin_b_s2, pin_b_s3;
  reg [`TMC_MODE_W-1:0] next_mode_ctrl;
  reg [PRSC_W-1:0] next_prsc_cnt;
  reg [`TMC_IRQ_W-1:0] next_irq_stat;
  reg [31:0] next_rdata;
  reg next_pin_a;
  reg next_pin_a_oe_n;
  wire timer_unit_enable;
  wire [1:0] operating_mode_select;
  wire pin_a_enable;
  wire pin_b_input_enable;
  wire pin_b_edge_polarity;
  wire pin_a_output_value;
  wire pwm_drive;
  wire pin_a_edge;
  wire pin_b_trig;
  wire preset_ev;
  wire tick;
  wire [`TMC_IRQ_W-1:0] ev_vec;
  wire wr_mode;
  wire wr_prsc;
  wire wr_cnt1;
  wire wr_cnt2;
  wire wr_cra;
  wire wr_crb;
  wire wr_pend;
  wire wr_irq_clr;
  wire wr_irq_en;

  function hit;
    input [`TMC_ADDR_W-1:0] a;
    input [`TMC_ADDR_W-1:0] ofs;
    begin
      hit = wr_i && (a == ofs);
    end
  endfunction

  // edge of the selected polarity: rising when pol is 1, falling when 0
  function edge_match;
    input pol;
    input now;
    input prev;
    begin
      edge_match = pol ? (now & ~prev) : (~now & prev);
    end
  endfunction

  assign operating_mode_select = mode_ctrl[`TMC_B_MODE_HI:`TMC_B_MODE_LO];
  assign pin_b_edge_polarity = mode_ctrl[`TMC_B_BEDG];
  assign pin_a_enable = mode_ctrl[`TMC_B_AEN];
  assign pin_b_input_enable = mode_ctrl[`TMC_B_BEN];
  assign pin_a_output_value = mode_ctrl[`TMC_B_AOUT];
  assign timer_unit_enable = mode_ctrl[`TMC_B_EN];

  // write decode, one strobe per writable register (none for the read-only status)
  assign wr_mode = hit(addr_i, `TMC_OFS_MODE);
  assign wr_prsc = hit(addr_i, `TMC_OFS_PRSC);
  assign wr_cnt1 = hit(addr_i, `TMC_OFS_CNT1);
  assign wr_cnt2 = hit(addr_i, `TMC_OFS_CNT2);
  assign wr_cra = hit(addr_i, `TMC_OFS_CRA);
  assign wr_crb = hit(addr_i, `TMC_OFS_CRB);
  assign wr_pend = hit(addr_i, `TMC_OFS_PEND);
  assign wr_irq_clr = hit(addr_i, `TMC_OFS_IRQ_CLR);
  assign wr_irq_en = hit(addr_i, `TMC_OFS_IRQ_EN);

  // pwm drive only when enabled and not in dual-input capture
  assign pwm_drive = timer_unit_enable && pin_a_enable &&
                     (operating_mode_select != `TMC_MD_CAPT2);
  assign pin_a_edge = pin_a_s2 ^ pin_a_s3;
  assign preset_ev = timer_unit_enable && pin_a_enable && pin_a_edge &&
                     (operating_mode_select == `TMC_MD_CAPT2);
  assign pin_b_trig = timer_unit_enable && pin_b_input_enable &&
                      edge_match(pin_b_edge_polarity, pin_b_s2, pin_b_s3);
  assign tick = timer_unit_enable && (prsc_cnt == clock_prescaler_value);
  assign ev_vec = {tick, pin_b_trig, preset_ev};

  // pin a synchroniser, third stage only feeds the edge detector
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_a_s1 <= 1'b0;
      pin_a_s2 <= 1'b0;
      pin_a_s3 <= 1'b0;
    end else begin
      pin_a_s1 <= pin_a_i;
      pin_a_s2 <= pin_a_s1;
      pin_a_s3 <= pin_a_s2;
    end
  end

  // pin b synchroniser, third stage only feeds the edge detector
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_b_s1 <= 1'b0;
      pin_b_s2 <= 1'b0;
      pin_b_s3 <= 1'b0;
    end else begin
      pin_b_s1 <= pin_b_i;
      pin_b_s2 <= pin_b_s1;
      pin_b_s3 <= pin_b_s2;
    end
  end

  // mode control next value; a software write beats the hardware copy
  always @* begin
    next_mode_ctrl = mode_ctrl;
    if (wr_mode) begin
      next_mode_ctrl = wdata_i[`TMC_MODE_W-1:0];
    end else if (pwm_drive && pin_a_edge) begin
      // copy only on a pin change, so the driven level cannot chase itself
      next_mode_ctrl[`TMC_B_AOUT] = pin_a_s2;
    end
  end

  // mode control register
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_ctrl <= `TMC_MODE_RST;
    end else begin
      mode_ctrl <= next_mode_ctrl;
    end
  end

  // prescaler count, cleared while disabled and after each tick
  always @* begin
    if (!timer_unit_enable || tick) begin
      next_prsc_cnt = {PRSC_W{1'b0}};
    end else begin
      next_prsc_cnt = prsc_cnt + 1'b1;
    end
  end

  // prescaler
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      clock_prescaler_value <= {PRSC_W{1'b0}};
      prsc_cnt <= {PRSC_W{1'b0}};
    end else begin
      if (wr_prsc) begin
        clock_prescaler_value <= wdata_i[PRSC_W-1:0];
      end
      prsc_cnt <= next_prsc_cnt;
    end
  end

  // counter and capture/reload holders
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      counter_one <= {CNT_W{1'b0}};
      counter_two <= {CNT_W{1'b0}};
      capture_reload_a <= {CNT_W{1'b0}};
      capture_reload_b <= {CNT_W{1'b0}};
      interrupt_pending_bits <= 4'h0;
    end else if (!timer_unit_enable) begin
      interrupt_pending_bits <= 4'h0;
    end else begin
      if (preset_ev) begin
        counter_one <= `TMC_PRESET_VAL;
      end else if (wr_cnt1) begin
        counter_one <= wdata_i[CNT_W-1:0];
      end
      if (wr_cnt2) begin
        counter_two <= wdata_i[CNT_W-1:0];
      end
      if (wr_cra) begin
        capture_reload_a <= wdata_i[CNT_W-1:0];
      end
      if (wr_crb) begin
        capture_reload_b <= wdata_i[CNT_W-1:0];
      end
      if (wr_pend) begin
        interrupt_pending_bits <= wdata_i[3:0];
      end
    end
  end

  // status next value, set wins over clear
  always @* begin
    next_irq_stat = irq_stat | ev_vec;
    if (wr_irq_clr) begin
      next_irq_stat = (irq_stat & ~wdata_i[`TMC_IRQ_W-1:0]) | ev_vec;
    end
  end

  // interrupt status and enable
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_stat <= {`TMC_IRQ_W{1'b0}};
      irq_en <= {`TMC_IRQ_W{1'b0}};
    end else begin
      if (wr_irq_en) begin
        irq_en <= wdata_i[`TMC_IRQ_W-1:0];
      end
      irq_stat <= next_irq_stat;
    end
  end

  // pin a direction and drive value; input unless the pwm path owns it
  always @* begin
    next_pin_a_oe_n = 1'b1;
    next_pin_a = 1'b0;
    if (pwm_drive) begin
      next_pin_a_oe_n = 1'b0;
      next_pin_a = pin_a_output_value;
    end
  end

  // registered outputs
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_a_o <= 1'b0;
      pin_a_oe_n_o <= 1'b1;
      timer_tick_o <= 1'b0;
      pulse_train_active_o <= 1'b0;
      mode_o <= 2'h0;
      irq_o <= 1'b0;
    end else begin
      pin_a_o <= next_pin_a;
      pin_a_oe_n_o <= next_pin_a_oe_n;
      timer_tick_o <= tick;
      pulse_train_active_o <= timer_unit_enable && mode_ctrl[`TMC_B_PTEN] &&
                              (operating_mode_select == `TMC_MD_PWM);
      mode_o <= operating_mode_select;
      irq_o <= |(irq_stat & irq_en);
    end
  end

  // read mux, zero unless a read strobe is present
  always @* begin
    next_rdata = 32'h00000000;
    if (rd_i) begin
      case (addr_i)
        `TMC_OFS_MODE: next_rdata = {{(32-`TMC_MODE_W){1'b0}}, mode_ctrl};
        `TMC_OFS_PRSC: next_rdata = {{(32-PRSC_W){1'b0}}, clock_prescaler_value};
        `TMC_OFS_CNT1: next_rdata = {{(32-CNT_W){1'b0}}, counter_one};
        `TMC_OFS_CNT2: next_rdata = {{(32-CNT_W){1'b0}}, counter_two};
        `TMC_OFS_CRA: next_rdata = {{(32-CNT_W){1'b0}}, capture_reload_a};
        `TMC_OFS_CRB: next_rdata = {{(32-CNT_W){1'b0}}, capture_reload_b};
        `TMC_OFS_PEND: next_rdata = {28'h0000000, interrupt_pending_bits};
        `TMC_OFS_IRQ_STAT: next_rdata = {{(32-`TMC_IRQ_W){1'b0}}, irq_stat};
        `TMC_OFS_IRQ_EN: next_rdata = {{(32-`TMC_IRQ_W){1'b0}}, irq_en};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // read data, one cycle after the strobe
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= 32'h00000000;
    end else begin
      rdata_o <= next_rdata;
    end
  end

endmodule
`default_nettype wire

// [tmc_props.sv]
// Purpose: port checks of the mode control block
// Assumes: one clock, async reset
// Notes: bound below
`timescale 1ns/100ps
`default_nettype none
module tmc_props (
  // ports
  input wire logic clk_i, sys_rst_i, wr_i, rd_i, pin_a_oe_n_o, timer_tick_o, pulse_train_active_o, irq_o,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i, rdata_o,
  input wire logic [1:0] mode_o
);
  wire w0 = wr_i && addr_i == 4'h0;
  wire [31:0] d = wdata_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0) else $error("stray data");
  a_pin_dir: assert property (w0 |-> ##2 pin_a_oe_n_o == !$past(d[7] && d[4] && d[1:0] != 2'h1, 2))
    else $error("dir");
  a_oe_hold: assert property (!$past(w0, 2) |-> $stable(pin_a_oe_n_o)) else $error("dir moved");
  a_off_quiet: assert property (w0 && !d[7] |-> ##2 (!timer_tick_o && pin_a_oe_n_o) [*2]) else $error("on");
  a_pt_sel: assert property (w0 |-> ##2 pulse_train_active_o == $past(d[8] && d[7] && d[1:0] == 2'h0, 2))
    else $error("pt");
  a_pt_mode: assert property (pulse_train_active_o |-> mode_o == 2'h0) else $error("pt mode");
  a_mode_copy: assert property (w0 |-> ##2 mode_o == $past(d[1:0], 2)) else $error("mode");
  a_irq_mask: assert property (wr_i && addr_i == 4'h9 && d[2:0] == 3'h0 |-> ##2 !irq_o) else $error("irq");
endmodule
bind tmc_timer_mode_control tmc_props u_props (.clk_i, .sys_rst_i, .wr_i, .rd_i, .pin_a_oe_n_o, .timer_tick_o,
  .pulse_train_active_o, .irq_o, .addr_i, .wdata_i, .rdata_o, .mode_o);
`default_nettype wire

// [tmc_pin_model.sv]
// Purpose: far side of the pins
// Assumes: pin a driven while enable low
// Notes: bench sets free levels
`timescale 1ns/100ps
`default_nettype none
module tmc_pin_model (
  // pins
  input wire logic drv_n_i, drv_i, a_i, b_i,
  output logic a_o, b_o
);
  assign a_o = drv_n_i ? a_i : drv_i;
  assign b_o = b_i;
endmodule
`default_nettype wire

// [test_timer_mode_control_pins.sv]
// Purpose: bench
// Assumes: 10 MHz clock
// Notes: register model in m
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; $display("[FAIL] %0t bad %h", $time, g); end end
module test_timer_mode_control_pins;
  logic clk_i = 1'h0, sys_rst_i = 1'h1, wr_i = 1'h0, rd_i = 1'h0, a_l = 1'h0, b_l = 1'h0;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0, s = 32'h000101A3, m [16];
  wire [31:0] rdata_o;
  wire [1:0] mode_o;
  wire pin_a_o, pin_a_oe_n_o, pin_a_i, pin_b_i, timer_tick_o, pulse_train_active_o, irq_o;
  int error_cnt = 0, total_checks = 0, cyc = 0, n;
  tmc_timer_mode_control DUT (.clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pin_a_i, .pin_a_o,
    .pin_a_oe_n_o, .pin_b_i, .timer_tick_o, .pulse_train_active_o, .mode_o, .irq_o);
  tmc_pin_model PINS (.drv_n_i(pin_a_oe_n_o), .drv_i(pin_a_o), .a_i(a_l), .b_i(b_l), .a_o(pin_a_i), .b_o(pin_b_i));
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic w3;
    repeat (3) @(negedge clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i) begin
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'h1;
    end
    @(posedge clk_i) wr_i <= 1'h0;
    if (a == 4'h8)
      m[7] &= ~d;
    else if (m[0][7] || a < 4'h2 || a == 4'h9)
      m[a] = d;
    if (!m[0][7])
      m[6] = 32'h0;
  endtask
  task automatic cr(input logic [3:0] a, input logic [31:0] k, e);
    @(posedge clk_i) begin
      addr_i <= a;
      rd_i <= 1'h1;
    end
    @(posedge clk_i) rd_i <= 1'h0;
    @(negedge clk_i);
    `CHK(rdata_o & k, e)
  endtask
  task automatic pin(input logic b);
    @(posedge clk_i) begin
      if (b)
        b_l <= ~b_l;
      else
        a_l <= ~a_l;
    end
    w3();
    w3();
  endtask
  task automatic gap(output int k);
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (timer_tick_o !== 1'h1 && k < 600);
  endtask
  task automatic finish_test();
    $display("%0d checks %0d errors", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    foreach (m[i]) m[i] = 32'h0;
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    for (int i = 0; i < 16; i++) cr(4'(i), 32'hFFFFFFFF, 32'h0);
    $display("reset done");
    for (int i = 0; i < 12; i++) begin
      s = lfsr(s);
      wr(4'h0, s & 32'h1EF);
      for (int j = 2; j < 7; j++) wr(4'(j), s & (j == 6 ? 32'hF : 32'hFFFF));
      for (int j = 0; j < 7; j++) cr(4'(j), 32'hFFFFFFFF, m[j]);
      `CHK(mode_o, m[0][1:0])
    end
    $display("regs done");
    wr(4'h0, 32'h91);
    wr(4'h2, 32'h0);
    wr(4'h9, 32'h1);
    pin(1'h0);
    cr(4'h2, 32'hFFFF, 32'hFFFF);
    `CHK(irq_o, 1'h1)
    wr(4'h8, 32'h1);
    w3();
    `CHK(irq_o, 1'h0)
    pin(1'h0);
    wr(4'h9, 32'h0);
    w3();
    `CHK(irq_o, 1'h0)
    for (int i = 0; i < 5; i++) begin
      wr(4'h0, i < 2 ? 32'hA8 : i < 4 ? 32'hA0 : 32'h88);
      wr(4'h8, 32'h7);
      pin(1'h1);
      cr(4'h7, 32'h2, i % 3 ? 32'h0 : 32'h2);
    end
    for (int i = 0; i < 3; i++) begin
      s = lfsr(s);
      wr(4'h1, i == 2 ? 32'hFF : {29'h0, s[2:0]});
      gap(n);
      gap(n);
      `CHK(n, i == 2 ? 256 : s[2:0] + 1)
    end
    wr(4'h6, 32'hF);
    wr(4'h0, 32'h90);
    w3();
    `CHK({pin_a_oe_n_o, pin_a_o}, 2'h0)
    wr(4'h0, 32'hD0);
    w3();
    w3();
    `CHK({pin_a_oe_n_o, pin_a_o}, 2'h1)
    cr(4'h0, 32'h1FF, 32'hD0);
    wr(4'h0, 32'h50);
    w3();
    `CHK({pin_a_oe_n_o, pin_a_o}, 2'h2)
    wr(4'h0, 32'h10);
    w3();
    cr(4'h6, 32'hF, m[6]);
    $display("pins done");
    finish_test();
  end
endmodule
`default_nettype wire
